// File: rtl/swp_pkg.sv
// swp_pkg: offsets, field positions, reset values and keys of the protection monitor
// assumes a 32-bit peripheral register port with byte offsets
package swp_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] MODE_OFS          = 8'h04;
  localparam logic [7:0] IRQ_EN_OFS        = 8'h14;
  localparam logic [7:0] IRQ_DIS_OFS       = 8'h18;
  localparam logic [7:0] CS_CFG0_OFS       = 8'h30;
  localparam logic [7:0] CS_CFG1_OFS       = 8'h34;
  localparam logic [7:0] CS_CFG2_OFS       = 8'h38;
  localparam logic [7:0] CS_CFG3_OFS       = 8'h3C;
  localparam logic [7:0] PROT_CTRL_OFS     = 8'hE4;
  localparam logic [7:0] PROT_STATUS_OFS   = 8'hE8;
  localparam logic [7:0] REVISION_OFS      = 8'hFC;

  // ************************************************************
  // fields
  // ************************************************************
  localparam int         KEY_LSB           = 8;
  localparam logic [23:0] PROT_KEY         = 24'h535049;
  localparam int         SRC_LSB           = 8;
  localparam int         STAT_BLOCKED      = 0;
  localparam int         STAT_SWRST        = 1;
  localparam int         STAT_CSACTIVE     = 2;
  localparam int         CS_COUNT          = 4;

  // ************************************************************
  // reset values and identity (version value arbitrary)
  // ************************************************************
  localparam logic [2:0]  STAT_RESET       = 3'h0;
  localparam logic [7:0]  SRC_RESET        = 8'h00;
  localparam logic [11:0] VERSION_VALUE    = 12'h123;
  localparam logic [3:0]  VARIANT_VALUE    = 4'h0;
  localparam logic [31:0] MODE_RESET       = 32'h00000000;
  localparam logic [31:0] CS_CFG_RESET     = 32'h00000000;
  localparam logic        PROT_EN_RESET    = 1'h0;
  localparam logic [3:0]  CS_SYNC_RESET    = 4'h0;
  localparam logic [31:0] RDATA_RESET      = 32'h00000000;

endpackage

// File: rtl/swp_cs_cfg.sv
// swp_cs_cfg: one protected chip-select configuration word
// assumes write strobe already qualified by the protection check
`timescale 1ns/1ps
`default_nettype none
module swp_cs_cfg (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // write side
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  // stored value
  output logic      [31:0] value
);

  // ************************************************************
  // storage
  // ************************************************************
  // load only on an allowed write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value <= swp_pkg::CS_CFG_RESET;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end

endmodule
`default_nettype wire

// File: rtl/swp_monitor.sv
// swp_monitor: write-protection monitor with mode and chip-select configuration words
// assumes single-cycle register port on MCLK, chip-select levels from the shifter
// assumes SOFT_RESET is a one-cycle pulse already on MCLK
// assumes one register access per cycle, never a read and a write together
// chip-select levels are seen two cycles late through the synchroniser
// the source field keeps the latest violating offset until the next violation
//
// Contract
// R1 - A write blocked by protection sets status bit 0 until the status register is read.
// R2 - A software reset while protection is on sets status bit 1 until a status read or a mode/irq/cs write.
// R3 - A mode write with any chip select active, or a cs write with its own select active, sets status bit 2.
// R4 - Concurrent violation kinds show as the OR of their bits.
// R5 - The source field holds the offset of the mode or cs register involved.
// R6 - A status read returns the gathered flags and starts a fresh accumulation.
// R7 - A read-only version register sits at 0xFC with version and variant fields.
// R8 - The enable bit changes only when the upper 24 bits carry the right key.
// R9 - Protection is on when the enable bit is one and off when zero.
// R10 - A blocked write leaves the protected register unchanged.
`timescale 1ns/1ps
`default_nettype none
module swp_monitor (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  // register port
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  // controller events
  input  wire logic        SOFT_RESET,
  input  wire logic [3:0]  CS_ACTIVE,
  // configuration out
  output logic      [31:0] MODE_CFG,
  output logic      [31:0] CS_CFG0,
  output logic      [31:0] CS_CFG1,
  output logic      [31:0] CS_CFG2,
  output logic      [31:0] CS_CFG3,
  output logic             PROT_EN
);

  // ************************************************************
  // declarations
  // ************************************************************
  // synchronised levels and protection state
  logic [3:0]  cs_meta_ff;
  logic [3:0]  cs_sync_ff;
  logic        prot_en_ff;
  // status, source, storage and read data
  logic [2:0]  stat_ff;
  logic [2:0]  nxt_stat;
  logic [7:0]  src_ff;
  logic [7:0]  nxt_src;
  logic [31:0] mode_ff;
  logic [31:0] rdata_ff;
  logic [31:0] cs_val [swp_pkg::CS_COUNT];
  // decode strobes
  logic        wr_mode;
  logic        wr_cs;
  logic [1:0]  cs_idx;
  logic        wr_prot;
  logic        wr_clear2;
  logic        cs_busy;
  logic        blocked;
  logic        rd_stat;

  // ************************************************************
  // pin synchroniser for chip-select levels
  // ************************************************************
  // two stages before any logic reads the levels
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      cs_meta_ff <= swp_pkg::CS_SYNC_RESET;
      cs_sync_ff <= swp_pkg::CS_SYNC_RESET;
    end else begin
      cs_meta_ff <= CS_ACTIVE;
      cs_sync_ff <= cs_meta_ff;
    end
  end

  // ************************************************************
  // decode
  // ************************************************************
  // address classes of protected registers
  assign wr_mode   = REG_WR && (REG_ADDR == swp_pkg::MODE_OFS);
  assign wr_cs     = REG_WR && (REG_ADDR >= swp_pkg::CS_CFG0_OFS) && (REG_ADDR <= swp_pkg::CS_CFG3_OFS)
                     && (REG_ADDR[1:0] == 2'h0);
  assign cs_idx    = REG_ADDR[3:2];

  // control, clear and status access
  assign wr_prot   = REG_WR && (REG_ADDR == swp_pkg::PROT_CTRL_OFS);
  assign wr_clear2 = wr_mode || wr_cs || (REG_WR && ((REG_ADDR == swp_pkg::IRQ_EN_OFS)
                     || (REG_ADDR == swp_pkg::IRQ_DIS_OFS)));
  assign rd_stat   = REG_RD && (REG_ADDR == swp_pkg::PROT_STATUS_OFS);

  // protection outcome of this access
  assign blocked   = prot_en_ff && (wr_mode || wr_cs); // R9
  assign cs_busy   = wr_mode ? (|cs_sync_ff) : (wr_cs && cs_sync_ff[cs_idx]); // R3

  // ************************************************************
  // protection enable
  // ************************************************************
  // keyed write only
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      prot_en_ff <= swp_pkg::PROT_EN_RESET;
    end else if (wr_prot && (REG_WDATA[31:swp_pkg::KEY_LSB] == swp_pkg::PROT_KEY)) begin // R8
      prot_en_ff <= REG_WDATA[0]; // R9
    end
  end

  // ************************************************************
  // protected configuration words
  // ************************************************************
  // mode word, held when blocked
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      mode_ff <= swp_pkg::MODE_RESET;
    end else if (wr_mode && !blocked) begin // R10
      mode_ff <= REG_WDATA;
    end
  end

  // one chip-select word per select
  genvar gi;
  generate
    for (gi = 0; gi < swp_pkg::CS_COUNT; gi++) begin : g_cs
      swp_cs_cfg u_cs (
        .clk     (MCLK),
        .rst_n   (RESETN),
        .wr_en   (wr_cs && !blocked && (cs_idx == 2'(gi))), // R10
        .wr_data (REG_WDATA),
        .value   (cs_val[gi])
      );
    end
  endgenerate

  // ************************************************************
  // violation status and source
  // ************************************************************
  // read clears, new events win over the clear
  always_comb begin
    nxt_stat = stat_ff;
    if (rd_stat) begin
      nxt_stat = swp_pkg::STAT_RESET; // R6
    end
    if (wr_clear2) begin
      nxt_stat[swp_pkg::STAT_SWRST] = 1'h0; // R2
    end
    if (blocked) begin
      nxt_stat[swp_pkg::STAT_BLOCKED] = 1'h1; // R1
    end
    if (SOFT_RESET && prot_en_ff) begin
      nxt_stat[swp_pkg::STAT_SWRST] = 1'h1; // R2
    end
    if (cs_busy) begin
      nxt_stat[swp_pkg::STAT_CSACTIVE] = 1'h1; // R3
    end
  end

  // source offset of the latest violation
  always_comb begin
    nxt_src = src_ff;
    if (blocked || cs_busy) begin
      nxt_src = REG_ADDR; // R5
    end
  end

  // status bits accumulate as an OR
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      stat_ff <= swp_pkg::STAT_RESET;
    end else begin
      stat_ff <= nxt_stat; // R4
    end
  end

  // source kept until the next violation, a read leaves it
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      src_ff <= swp_pkg::SRC_RESET;
    end else begin
      src_ff <= nxt_src; // R5
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  // registered read mux, unmapped reads zero
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      rdata_ff <= swp_pkg::RDATA_RESET;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        swp_pkg::MODE_OFS:        rdata_ff <= mode_ff;
        swp_pkg::CS_CFG0_OFS:     rdata_ff <= cs_val[0];
        swp_pkg::CS_CFG1_OFS:     rdata_ff <= cs_val[1];
        swp_pkg::CS_CFG2_OFS:     rdata_ff <= cs_val[2];
        swp_pkg::CS_CFG3_OFS:     rdata_ff <= cs_val[3];
        swp_pkg::PROT_CTRL_OFS:   rdata_ff <= {31'h0, prot_en_ff};
        swp_pkg::PROT_STATUS_OFS: rdata_ff <= {16'h0, src_ff, 5'h0, stat_ff};
        swp_pkg::REVISION_OFS:    rdata_ff <= {12'h0, swp_pkg::VARIANT_VALUE, 4'h0,
                                               swp_pkg::VERSION_VALUE}; // R7
        default:                  rdata_ff <= 32'h00000000;
      endcase
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // each output straight from its flop
  assign REG_RDATA = rdata_ff;
  assign MODE_CFG  = mode_ff;
  assign CS_CFG0   = cs_val[0];
  assign CS_CFG1   = cs_val[1];
  assign CS_CFG2   = cs_val[2];
  assign CS_CFG3   = cs_val[3];
  assign PROT_EN   = prot_en_ff;

endmodule
`default_nettype wire

// File: dv/swp_monitor_asserts.sv
// swp_monitor_asserts: port checks on the protection monitor
// assumes bound onto swp_monitor, one MCLK domain
`timescale 1ns/1ps
`default_nettype none
module swp_monitor_asserts (
  // clock, reset, register port
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  // events and configuration
  input wire logic        SOFT_RESET,
  input wire logic [31:0] MODE_CFG,
  input wire logic [31:0] CS_CFG3,
  input wire logic        PROT_EN
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // ************************************************************
  // steps of register and status accesses
  // ************************************************************
  sequence s_rd;
    REG_RD && REG_ADDR == swp_pkg::PROT_STATUS_OFS && !REG_WR && !SOFT_RESET;
  endsequence
  sequence s_blk;
    REG_WR && REG_ADDR == swp_pkg::MODE_OFS && PROT_EN;
  endsequence
  sequence s_key;
    REG_WR && REG_ADDR == swp_pkg::PROT_CTRL_OFS;
  endsequence
  sequence s_idle;
    !REG_RD && !REG_WR && !SOFT_RESET;
  endsequence
  AST_KEY_OK: assert property (s_key ##0 REG_WDATA[31:8] == swp_pkg::PROT_KEY |=> PROT_EN == $past(REG_WDATA[0]))
    else $error("enable not taken with good key");
  AST_KEY_BAD: assert property (s_key ##0 REG_WDATA[31:8] != swp_pkg::PROT_KEY |=> $stable(PROT_EN))
    else $error("enable moved with bad key");
  AST_BLK_HOLD: assert property (s_blk |=> $stable(MODE_CFG))
    else $error("blocked mode write landed");
  AST_CS_HOLD: assert property (REG_WR && REG_ADDR == swp_pkg::CS_CFG3_OFS && PROT_EN |=> $stable(CS_CFG3))
    else $error("blocked cs write landed");
  AST_BLK_STAT: assert property (s_blk ##1 s_idle ##1 s_idle ##1 s_rd |=>
    REG_RDATA[0] && REG_RDATA[15:8] == swp_pkg::MODE_OFS)
    else $error("blocked write not reported");
  AST_SWRST: assert property ((SOFT_RESET && PROT_EN) ##1 s_idle ##1 s_rd |=> REG_RDATA[1])
    else $error("soft reset not reported");
  AST_RD_CLR: assert property (s_rd ##1 s_idle ##1 s_rd |=> REG_RDATA[2:0] == 3'h0)
    else $error("status not cleared by read");
  AST_VER: assert property (REG_RD && REG_ADDR == swp_pkg::REVISION_OFS |=>
    REG_RDATA == {12'h000, swp_pkg::VARIANT_VALUE, 4'h0, swp_pkg::VERSION_VALUE})
    else $error("version value wrong");
  AST_RD_HOLD: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
    else $error("read data moved without read");
endmodule
bind swp_monitor swp_monitor_asserts u_chk (.MCLK(MCLK), .RESETN(RESETN), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SOFT_RESET(SOFT_RESET),
  .MODE_CFG(MODE_CFG), .CS_CFG3(CS_CFG3), .PROT_EN(PROT_EN));
`default_nettype wire

// File: dv/swp_monitor_tb_top.sv
// swp_monitor_tb_top: self-checking bench for the protection monitor
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
`default_nettype none
module swp_monitor_tb_top;
  logic              MCLK = 1'h0, RESETN = 1'h0, REG_WR = 1'h0, REG_RD = 1'h0, SOFT_RESET = 1'h0, pend = 1'h0;
  logic [7:0]        REG_ADDR = 8'h00;
  logic [31:0]       REG_WDATA = 32'h0, d;
  logic [3:0]        CS_ACTIVE = 4'h0;
  wire logic [31:0]  REG_RDATA, MODE_CFG, CS_CFG0, CS_CFG1, CS_CFG2, CS_CFG3;
  wire logic         PROT_EN;
  wire logic [159:0] cfgv = {CS_CFG3, CS_CFG2, CS_CFG1, CS_CFG0, MODE_CFG};
  logic [31:0]       sh [5];
  logic [7:0]        ofs [5] = '{8'h04, 8'h30, 8'h34, 8'h38, 8'h3C};
  logic [7:0]        st = swp_pkg::PROT_STATUS_OFS;
  logic [31:0]       exp_q [$];
  int                bad_count = 0, checks_done = 0;
  // ************************************************************
  // clock, design, tasks
  // ************************************************************
  always #12.5 MCLK = ~MCLK;
  swp_monitor dut (.MCLK(MCLK), .RESETN(RESETN), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SOFT_RESET(SOFT_RESET), .CS_ACTIVE(CS_ACTIVE),
    .MODE_CFG(MODE_CFG), .CS_CFG0(CS_CFG0), .CS_CFG1(CS_CFG1), .CS_CFG2(CS_CFG2), .CS_CFG3(CS_CFG3),
    .PROT_EN(PROT_EN));
  task automatic step(int n = 1);
    repeat (n) @(posedge MCLK);
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    step();
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    step();
    REG_WR <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    step();
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    exp_q.push_back(e);
    step();
    REG_RD <= 1'b0;
  endtask
  task automatic kick;
    step();
    SOFT_RESET <= 1'b1;
    step();
    SOFT_RESET <= 1'b0;
  endtask
  task automatic key(logic [23:0] k, logic en, logic [31:0] e);
    wr(swp_pkg::PROT_CTRL_OFS, {k, 7'h00, en});
    step();
    chk("enable", e, {31'h0, PROT_EN});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // read data compared one cycle after each taken read
  always @(posedge MCLK) begin
    if (pend) begin
      chk("read data", exp_q.pop_front(), REG_RDATA);
    end
    pend <= REG_RD;
  end
  // hang guard
  initial begin
    step(20000);
    bad_count++;
    complete_run();
  end
  // main sequence
  initial begin
    d = $urandom(32'hA79A181B);
    foreach (sh[i]) sh[i] = (i == 0) ? swp_pkg::MODE_RESET : swp_pkg::CS_CFG_RESET;
    step(16);
    RESETN <= 1'b1;
    rd(st, 32'h0);
    rd(swp_pkg::REVISION_OFS, {12'h000, swp_pkg::VARIANT_VALUE, 4'h0, swp_pkg::VERSION_VALUE});
    rd(8'hC0, 32'h0);
    $display("test 1 done");
    foreach (ofs[i]) begin
      sh[i] = $urandom;
      wr(ofs[i], sh[i]);
      step();
      chk("config", sh[i], cfgv[i*32 +: 32]);
    end
    rd(st, 32'h0);
    key(24'h535048, 1'b1, 32'h0);
    key(swp_pkg::PROT_KEY, 1'b1, 32'h1);
    $display("test 2 done");
    foreach (ofs[i]) begin
      wr(ofs[i], $urandom);
      step();
      chk("config", sh[i], cfgv[i*32 +: 32]);
      rd(st, {16'h0, ofs[i], 8'h01});
    end
    rd(st, {16'h0, ofs[4], 8'h00});
    $display("test 3 done");
    for (int j = 0; j < 2; j++) begin
      kick();
      rd(st, {16'h0, ofs[4], 8'h02});
      kick();
      wr(j ? swp_pkg::IRQ_DIS_OFS : swp_pkg::IRQ_EN_OFS, $urandom);
      rd(st, {16'h0, ofs[4], 8'h00});
    end
    $display("test 4 done");
    key(swp_pkg::PROT_KEY, 1'b0, 32'h0);
    CS_ACTIVE <= 4'h4;
    step(3);
    d = $urandom;
    wr(ofs[1], d);
    rd(st, {16'h0, ofs[4], 8'h00});
    chk("config", d, CS_CFG0);
    wr(ofs[3], d);
    rd(st, 32'h00003804);
    wr(ofs[0], d);
    rd(st, 32'h00000404);
    $display("test 5 done");
    key(swp_pkg::PROT_KEY, 1'b1, 32'h1);
    wr(ofs[0], $urandom);
    kick();
    rd(st, 32'h00000407);
    $display("test 6 done");
    step(3);
    complete_run();
  end
endmodule
`default_nettype wire
